// file: hw/sdram_cmd_ctrl.sv
// Controller end: command state machine, refresh handshake and nibble data path
// Summary of operation
// - Master raises refresh request to ask refresh.
// - Acknowledge held high through whole refresh.
// - Master holds request until acknowledge rises.
// - No accesses accepted while acknowledge high.
// - Request still high means another refresh.
// - Refresh state issues one command, waits, idles.
// - Four-bit memory bus joins sixteen-bit bus.
// - Commands driven one clock after state entry.
// - Read/write select valid before command state.
// - CAS latency two, burst length four.
// - Stay idle until initialization done.
// - Access starts on request low, strobe low.
// - Read/write carry address bit ten high.
`timescale 1ns/1ps
`default_nettype none
`include "sdram_ctl_params.svh"
module sdram_cmd_ctrl (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Bus master link
  sdram_sys_if.ctrl sys,
  // SDRAM pins
  output logic sdr_cs_n_o,
  output logic sdr_ras_n_o,
  output logic sdr_cas_n_o,
  output logic sdr_we_n_o,
  output logic [`BANK_W-1:0] sdr_ba_o,
  output logic [`ADDR_W-1:0] sdr_a_o,
  input wire logic [`NIB_W-1:0] sdr_dq_i,
  output logic [`NIB_W-1:0] sdr_dq_o,
  output logic sdr_dq_oe_n_o
);
  typedef struct packed {
    sdram_ctl_pkg::command_state_machine_t st;
    logic [`CNT_W-1:0] cnt;
    logic [3:0] cmd;
    logic [`BANK_W-1:0] ba;
    logic [`ADDR_W-1:0] a;
    logic ack;
    logic rnw;
    logic [`WORD_W-1:0] rword;
    logic [`WORD_W-1:0] wword;
    logic rvalid;
    logic wtaken;
    logic [`NIB_W-1:0] dq;
    logic dq_oe_n;
    logic [`SYS_ADDR_W-1:0] addr;
  } ctrl_state_t;

  ctrl_state_t cur_ff, nxt_cur;

  // column word with the auto precharge bit set
  // Closing the row on every access costs an activate each time but needs no open-row tracking
  function automatic logic [`ADDR_W-1:0] col_with_ap(input logic [`SYS_ADDR_W-1:0] sys_addr);
    logic [`ADDR_W-1:0] word;
    word = `ADDR_W'(sys_addr[`SYS_ADDR_W-`BANK_W-`ADDR_W-1:0]);
    word[`AP_BIT] = 1'b1;
    return word;
  endfunction

  // Next state and pin values
  always_comb begin
    nxt_cur = cur_ff;
    // Command, pulses and bus enable default to their idle values
    nxt_cur.cmd = `CMD_NOP;
    nxt_cur.rvalid = 1'b0;
    nxt_cur.wtaken = 1'b0;
    nxt_cur.dq_oe_n = 1'b1;
    unique case (cur_ff.st)
      sdram_ctl_pkg::ST_IDLE: begin
        // Ack only stands while away from idle
        nxt_cur.ack = 1'b0;
        if (sys.init_done) begin
          if (sys.ref_req) begin
            nxt_cur.ack = 1'b1;
            nxt_cur.st = sdram_ctl_pkg::ST_AUTO_REFRESH;
          end else if (!sys.address_strobe_n) begin
            nxt_cur.addr = sys.addr;
            nxt_cur.st = sdram_ctl_pkg::ST_ACTIVATE;
          end
        end
      end
      sdram_ctl_pkg::ST_AUTO_REFRESH: begin
        nxt_cur.cmd = `CMD_REFRESH;
        nxt_cur.cnt = `CNT_W'(`TRFC_CYC - 1);
        nxt_cur.st = sdram_ctl_pkg::ST_REFRESH_WAIT;
      end
      sdram_ctl_pkg::ST_REFRESH_WAIT: begin
        // strobes ignored meanwhile
        // Ack falls together with the return to idle
        if (cur_ff.cnt <= `CNT_W'(1)) begin
          nxt_cur.ack = 1'b0;
          nxt_cur.st = sdram_ctl_pkg::ST_IDLE;
        end
        nxt_cur.cnt = cur_ff.cnt - `CNT_W'(1);
      end
      sdram_ctl_pkg::ST_ACTIVATE: begin
        nxt_cur.cmd = `CMD_ACTIVE;
        nxt_cur.ba = cur_ff.addr[`SYS_ADDR_W-1 -: `BANK_W];
        nxt_cur.a = cur_ff.addr[`SYS_ADDR_W-`BANK_W-1 -: `ADDR_W];
        nxt_cur.cnt = `CNT_W'(`TRCD_CYC - 1);
        nxt_cur.rnw = sys.read_not_write_select;
        nxt_cur.st = sdram_ctl_pkg::ST_ACTIVATE_DELAY;
      end
      sdram_ctl_pkg::ST_ACTIVATE_DELAY: begin
        nxt_cur.cnt = cur_ff.cnt - `CNT_W'(1);
        // Resample select on the last delay clock
        if (cur_ff.cnt <= `CNT_W'(1)) begin
          nxt_cur.st = sys.read_not_write_select ? sdram_ctl_pkg::ST_READ_AUTOPRECHARGE
                                                 : sdram_ctl_pkg::ST_WRITE_AUTOPRECHARGE;
          // Write word latched with the deciding select sample
          nxt_cur.wword = sys.wdata;
        end
      end
      sdram_ctl_pkg::ST_READ_AUTOPRECHARGE: begin
        nxt_cur.cmd = `CMD_READ;
        nxt_cur.a = col_with_ap(cur_ff.addr);
        nxt_cur.cnt = `CNT_W'(`CAS_LAT);
        nxt_cur.st = sdram_ctl_pkg::ST_CAS_WAIT;
      end
      sdram_ctl_pkg::ST_CAS_WAIT: begin
        // CAS latency, then the burst count
        nxt_cur.cnt = cur_ff.cnt - `CNT_W'(1);
        if (cur_ff.cnt <= `CNT_W'(1)) begin
          nxt_cur.cnt = `CNT_W'(`BURST_LEN);
          nxt_cur.st = sdram_ctl_pkg::ST_READ_DATA;
        end
      end
      sdram_ctl_pkg::ST_READ_DATA: begin
        nxt_cur.rword = {sdr_dq_i, cur_ff.rword[`WORD_W-1:`NIB_W]};
        nxt_cur.cnt = cur_ff.cnt - `CNT_W'(1);
        if (cur_ff.cnt <= `CNT_W'(1)) begin
          nxt_cur.rvalid = 1'b1;
          nxt_cur.st = sdram_ctl_pkg::ST_IDLE;
        end
      end
      sdram_ctl_pkg::ST_WRITE_AUTOPRECHARGE: begin
        nxt_cur.cmd = `CMD_WRITE;
        nxt_cur.a = col_with_ap(cur_ff.addr);
        nxt_cur.dq = cur_ff.wword[`NIB_W-1:0];
        nxt_cur.dq_oe_n = 1'b0;
        // Word is taken here; recovery still keeps this end busy
        nxt_cur.wtaken = 1'b1;
        nxt_cur.wword = cur_ff.wword >> `NIB_W;
        nxt_cur.cnt = `CNT_W'(`BURST_LEN - 1 + `TDAL_CYC);
        nxt_cur.st = sdram_ctl_pkg::ST_WRITE_DATA;
      end
      sdram_ctl_pkg::ST_WRITE_DATA: begin
        // Remaining beats, then recovery with bus released
        // One counter covers the beats and the recovery
        if (cur_ff.cnt > `CNT_W'(`TDAL_CYC)) begin
          nxt_cur.dq = cur_ff.wword[`NIB_W-1:0];
          nxt_cur.dq_oe_n = 1'b0;
          nxt_cur.wword = cur_ff.wword >> `NIB_W;
        end
        nxt_cur.cnt = cur_ff.cnt - `CNT_W'(1);
        if (cur_ff.cnt <= `CNT_W'(1)) begin
          nxt_cur.st = sdram_ctl_pkg::ST_IDLE;
        end
      end
      // Illegal one-hot codes fall back to idle
      default: nxt_cur.st = sdram_ctl_pkg::ST_IDLE;
    endcase
  end

  // State register, reset to idle with NOP on the pins
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // Whole struct cleared first, so no field starts unknown
      cur_ff <= '0;
      cur_ff.st <= sdram_ctl_pkg::ST_IDLE;
      cur_ff.cmd <= `CMD_NOP;
      cur_ff.dq_oe_n <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Outputs straight from flops
  assign {sdr_cs_n_o, sdr_ras_n_o, sdr_cas_n_o, sdr_we_n_o} = cur_ff.cmd;
  assign sdr_ba_o = cur_ff.ba;
  assign sdr_a_o = cur_ff.a;
  assign sdr_dq_o = cur_ff.dq;
  assign sdr_dq_oe_n_o = cur_ff.dq_oe_n;

  // Bus master link, also straight from flops
  assign sys.ref_ack = cur_ff.ack;
  assign sys.rdata = cur_ff.rword;
  assign sys.rdata_valid = cur_ff.rvalid;
  assign sys.wdata_taken = cur_ff.wtaken;
endmodule // sdram_cmd_ctrl
`default_nettype wire

// file: hw/sdram_ctl_params.svh
// Timing, command and field constants for the SDRAM refresh and data path ends
`ifndef SDRAM_CTL_PARAMS_SVH
`define SDRAM_CTL_PARAMS_SVH
`define CLK_PERIOD_PS 4000
`define TRCD_PS 20000
`define TRFC_PS 70000
`define TDAL_PS 35000
// Least times round up to whole cycles
`define TRCD_CYC ((`TRCD_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define TRFC_CYC ((`TRFC_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define TDAL_CYC ((`TDAL_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CAS_LAT 2
`define BURST_LEN 4
`define CNT_W 5
`define BEAT_W 2
`define NIB_W 4
`define WORD_W 16
`define ADDR_W 12
`define BANK_W 2
`define SYS_ADDR_W 23
`define AP_BIT 10
// Commands as {cs_n, ras_n, cas_n, we_n}
`define CMD_NOP 4'h7
`define CMD_ACTIVE 4'h3
`define CMD_READ 4'h5
`define CMD_WRITE 4'h4
`define CMD_REFRESH 4'h1
`endif

// file: hw/sdram_ctl_pkg.sv
// Types used only by the controller end of the SDRAM link
package sdram_ctl_pkg;
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_AUTO_REFRESH = 10'h002,
    ST_REFRESH_WAIT = 10'h004,
    ST_ACTIVATE = 10'h008,
    ST_ACTIVATE_DELAY = 10'h010,
    ST_READ_AUTOPRECHARGE = 10'h020,
    ST_CAS_WAIT = 10'h040,
    ST_READ_DATA = 10'h080,
    ST_WRITE_AUTOPRECHARGE = 10'h100,
    ST_WRITE_DATA = 10'h200
  } command_state_machine_t;
endpackage

// file: hw/sdram_sys_if.sv
// Bus-master side link between the controller and its user
`timescale 1ns/1ps
`default_nettype none
`include "sdram_ctl_params.svh"
interface sdram_sys_if;
  logic ref_req;
  logic ref_ack;
  logic address_strobe_n;
  logic read_not_write_select;
  logic [`SYS_ADDR_W-1:0] addr;
  logic [`WORD_W-1:0] wdata;
  logic [`WORD_W-1:0] rdata;
  logic rdata_valid;
  logic wdata_taken;
  logic init_done;
  modport ctrl (input ref_req, address_strobe_n, read_not_write_select, addr, wdata, init_done,
                output ref_ack, rdata, rdata_valid, wdata_taken);
  modport master (output ref_req, address_strobe_n, read_not_write_select, addr, wdata,
                  input ref_ack, rdata, rdata_valid, wdata_taken, init_done);
endinterface
`default_nettype wire

// file: hw/sdram_bus_master.sv
// Bus master end: issues refreshes and single-word accesses to the controller
`timescale 1ns/1ps
`default_nettype none
`include "sdram_ctl_params.svh"
module sdram_bus_master (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Controller link
  sdram_sys_if.master sys,
  // User side
  input wire logic refresh_i,
  input wire logic access_i,
  input wire logic read_i,
  input wire logic [`SYS_ADDR_W-1:0] addr_i,
  input wire logic [`WORD_W-1:0] wdata_i,
  output logic busy_o,
  output logic [`WORD_W-1:0] rdata_o,
  output logic done_o
);
  typedef struct packed {
    logic req;
    logic strobe_n;
    logic rnw;
    logic [`SYS_ADDR_W-1:0] addr;
    logic [`WORD_W-1:0] wdata;
    logic busy;
    logic [`WORD_W-1:0] rdata;
    logic done;
    logic [`CNT_W-1:0] hold;
  } master_state_t;

  master_state_t cur_ff, nxt_cur;

  // Requests; accesses wait until the refresh handshake is over
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    nxt_cur.strobe_n = 1'b1;
    if (sys.ref_ack) begin
      nxt_cur.req = 1'b0;
    end else if (refresh_i && !cur_ff.busy) begin
      nxt_cur.req = 1'b1;
    end
    if (access_i && !cur_ff.busy && !cur_ff.req && !refresh_i && !sys.ref_ack && sys.init_done) begin
      nxt_cur.strobe_n = 1'b0;
      nxt_cur.busy = 1'b1;
      nxt_cur.addr = addr_i;
      nxt_cur.wdata = wdata_i;
      nxt_cur.rnw = read_i;
    end
    // Done at the word or first beat; a write stays busy through the other end's recovery
    if (cur_ff.busy && (sys.rdata_valid || sys.wdata_taken)) begin
      nxt_cur.done = 1'b1;
      if (sys.rdata_valid) begin
        nxt_cur.busy = 1'b0;
        nxt_cur.rdata = sys.rdata;
      end else begin
        nxt_cur.hold = `CNT_W'(`BURST_LEN - 1 + `TDAL_CYC);
      end
    end
    // A strobe sent before the other end is idle again would be lost
    if (cur_ff.hold != '0) begin
      nxt_cur.hold = cur_ff.hold - `CNT_W'(1);
      if (cur_ff.hold == `CNT_W'(1)) begin
        nxt_cur.busy = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cur_ff <= '0;
      cur_ff.strobe_n <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign sys.ref_req = cur_ff.req;
  assign sys.address_strobe_n = cur_ff.strobe_n;
  assign sys.read_not_write_select = cur_ff.rnw;
  assign sys.addr = cur_ff.addr;
  assign sys.wdata = cur_ff.wdata;
  assign busy_o = cur_ff.busy;
  assign rdata_o = cur_ff.rdata;
  assign done_o = cur_ff.done;
endmodule // sdram_bus_master
`default_nettype wire

// file: testbench/sdram_link_sva.sv
// Checker for the link between the controller and the bus master
`timescale 1ns/1ps
`default_nettype none
`include "sdram_ctl_params.svh"
module sdram_link_sva (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Link signals
  input wire logic ref_req,
  input wire logic ref_ack,
  input wire logic address_strobe_n,
  input wire logic read_not_write_select,
  input wire logic rdata_valid,
  input wire logic wdata_taken,
  input wire logic init_done
);
  // Ack stands from the refresh state through the last wait cycle
  localparam int AckLen = `TRFC_CYC;
  logic [7:0] ack_cnt_ff;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Length of the running acknowledge, cleared when it drops
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) ack_cnt_ff <= 8'h00;
    else ack_cnt_ff <= ref_ack ? ack_cnt_ff + 8'h01 : 8'h00;
  end
  ack_cause_a: assert property ($rose(ref_ack) |-> $past(ref_req))
    else $error("ack without request");
  ack_init_a: assert property (ref_ack |-> init_done)
    else $error("ack before init done");
  ack_len_a: assert property ($fell(ref_ack) |-> ack_cnt_ff == AckLen)
    else $error("ack length wrong");
  req_hold_a: assert property ($fell(ref_req) |-> ref_ack)
    else $error("request dropped early");
  req_drop_a: assert property ($rose(ref_ack) |=> !ref_req)
    else $error("request kept after ack");
  ack_quiet_a: assert property (ref_ack |-> address_strobe_n && !rdata_valid && !wdata_taken)
    else $error("access during refresh");
  strobe_gate_a: assert property (!address_strobe_n |-> !ref_req ##1 address_strobe_n)
    else $error("strobe with refresh pending");
  sel_hold_a: assert property (!address_strobe_n |=> $stable(read_not_write_select) [*5])
    else $error("select changed during activate");
  read_time_a: assert property (!address_strobe_n && read_not_write_select |-> ##[8:18] rdata_valid)
    else $error("read word late");
  write_time_a: assert property (!address_strobe_n && !read_not_write_select |-> ##[5:12] wdata_taken)
    else $error("write data late");
endmodule // sdram_link_sva
`default_nettype wire

// file: testbench/sdram_refresh_and_datapath_tb_top.sv
// Testbench joining both ends of the link, with a small memory data model
`timescale 1ns/1ps
`default_nettype none
`include "sdram_ctl_params.svh"
module sdram_refresh_and_datapath_tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic refresh = 1'b0;
  logic access = 1'b0;
  logic rd = 1'b0;
  logic [`SYS_ADDR_W-1:0] addr = '0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] nib_word = 16'h0000;
  logic [15:0] rdata;
  logic busy, done, cs_n, ras_n, cas_n, we_n, oe_n;
  logic [1:0] ba;
  logic [11:0] sa;
  logic [3:0] dq_i = 4'h0;
  logic [3:0] dq_o;
  int error_cnt = 0;
  int checks = 0;
  int rd_k = 9;
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  sdram_sys_if sdram_sys_if_i ();
  sdram_cmd_ctrl sdram_cmd_ctrl_i (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .sys(sdram_sys_if_i),
    .sdr_cs_n_o(cs_n), .sdr_ras_n_o(ras_n), .sdr_cas_n_o(cas_n), .sdr_we_n_o(we_n), .sdr_ba_o(ba),
    .sdr_a_o(sa), .sdr_dq_i(dq_i), .sdr_dq_o(dq_o), .sdr_dq_oe_n_o(oe_n));
  sdram_bus_master sdram_bus_master_i (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .sys(sdram_sys_if_i),
    .refresh_i(refresh), .access_i(access), .read_i(rd), .addr_i(addr), .wdata_i(wdata),
    .busy_o(busy), .rdata_o(rdata), .done_o(done));
  sdram_link_sva sdram_link_sva_i (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
    .ref_req(sdram_sys_if_i.ref_req), .ref_ack(sdram_sys_if_i.ref_ack),
    .address_strobe_n(sdram_sys_if_i.address_strobe_n),
    .read_not_write_select(sdram_sys_if_i.read_not_write_select),
    .rdata_valid(sdram_sys_if_i.rdata_valid), .wdata_taken(sdram_sys_if_i.wdata_taken),
    .init_done(sdram_sys_if_i.init_done));
  // Free-running clock
  initial forever #2 ref_clk = ~ref_clk;
  // Burst two cycles after READ; idle bus toggles so stale data never matches
  always @(negedge ref_clk) begin
    rd_k = (cmd === `CMD_READ) ? 0 : rd_k + 1;
    dq_i <= (rd_k >= 2 && rd_k <= 5) ? nib_word[4*(rd_k-2) +: 4] : ~dq_i;
  end
  task automatic report_and_stop;
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait for a command on the pins; n counts the cycles spent
  task automatic wait_cmd(input logic [3:0] c, output int n);
    n = 0;
    while (cmd !== c) begin
      @(negedge ref_clk);
      n++;
      if (n > 80) begin
        error_cnt++;
        report_and_stop();
      end
    end
  endtask
  task automatic start(input logic r, input logic [`SYS_ADDR_W-1:0] a);
    @(negedge ref_clk);
    addr = a;
    rd = r;
    access = 1'b1;
    @(negedge ref_clk);
    access = 1'b0;
  endtask
  task automatic refresh_test;
    int n;
    int hi;
    int refs;
    @(negedge ref_clk) refresh = 1'b1;
    @(negedge ref_clk) refresh = 1'b0;
    repeat (20) @(negedge ref_clk);
    chk("ack before init", 16'h0000, {15'h0, sdram_sys_if_i.ref_ack});
    sdram_sys_if_i.init_done = 1'b1;
    hi = 0;
    refs = 0;
    for (n = 0; n < 60; n++) begin
      @(negedge ref_clk);
      if (sdram_sys_if_i.ref_ack === 1'b1) hi++;
      if (cmd === `CMD_REFRESH) refs++;
    end
    chk("ack cycles", 16'(`TRFC_CYC), 16'(hi));
    chk("refresh commands", 16'h0001, 16'(refs));
  endtask
  // Refresh held long enough that a second refresh must follow the first
  task automatic repeat_refresh_test;
    int n;
    int refs;
    refs = 0;
    @(negedge ref_clk);
    refresh = 1'b1;
    for (n = 0; n < 60; n++) begin
      @(negedge ref_clk);
      if (n == 24) refresh = 1'b0;
      if (cmd === `CMD_REFRESH) refs++;
    end
    chk("repeated refresh commands", 16'h0002, 16'(refs));
  endtask
  task automatic write_test;
    int n;
    int t;
    logic [15:0] got;
    wdata = 16'hC3A5;
    start(1'b0, {2'h2, 12'hA5B, 9'h1C4});
    chk("write busy", 16'h0001, {15'h0, busy});
    wait_cmd(`CMD_ACTIVE, n);
    chk("strobe to act", 16'h0002, 16'(n));
    chk("act bank row", 16'h2A5B, {2'h0, ba, sa});
    wait_cmd(`CMD_WRITE, t);
    chk("act to write", 16'(`TRCD_CYC), 16'(t));
    chk("write column", 16'h05C4, {4'h0, sa});
    for (n = 0; n < 4; n++) begin
      chk("write oe_n", 16'h0000, {15'h0, oe_n});
      got[4*n +: 4] = dq_o;
      @(negedge ref_clk);
    end
    chk("write beats", 16'hC3A5, got);
    repeat (14) @(negedge ref_clk);
    chk("busy after recovery", 16'h0000, {15'h0, busy});
  endtask
  task automatic read_test;
    int n;
    nib_word = 16'h5E17;
    start(1'b1, {2'h1, 12'h3C0, 9'h0FF});
    wait_cmd(`CMD_READ, n);
    chk("read column", 16'h04FF, {4'h0, sa});
    chk("read oe_n", 16'h0001, {15'h0, oe_n});
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    chk("read done", 16'h0001, {15'h0, done});
    chk("read word", 16'h5E17, rdata);
  endtask
  // Reset, then the scenarios in turn
  initial begin
    sdram_sys_if_i.init_done = 1'b0;
    repeat (6) @(negedge ref_clk);
    rst_b = 1'b1;
    refresh_test();
    repeat_refresh_test();
    write_test();
    read_test();
    repeat (10) @(negedge ref_clk);
    report_and_stop();
  end
endmodule // sdram_refresh_and_datapath_tb_top
`default_nettype wire
